// [bench/angle_spi_port_tb.sv]
// Purpose: self-checking bench of the angle sensor register port
// Assumes: host model drives the link, a stub plays the measurement engine
// Notes: random values come from an lfsr with a fixed start
`timescale 1ns/100ps
module angle_spi_port_tb;
    import angle_spi_pkg::*;
    logic clock, sys_rst, wm, hostOe, mosi, sclk, selectN, sdoOut, sdoOe;
    logic sdioOut, sdioOe, measureStart, resultReadyN, porCellOff, sawOe = 1'b0;
    logic measureDone = 1'b0;
    logic [5:0] gainControl, g, old;
    logic [13:0] angleValue = 14'h0000, angleNext, a1;
    logic [31:0] lfsr = 32'h5FF8B39C;
    logic [15:0] rx;
    int nErrors = 0, nTests = 0, busy = 0, nStarts = 0;
    wire shared = sdioOe ? sdioOut : (hostOe ? mosi : ~mosi);
    wire miso = sdoOe ? sdoOut : ~mosi;
    angle_spi_port angle_spi_port_i (.clock(clock), .sys_rst(sys_rst), .sclk(sclk),
        .selectN(selectN), .sdiIn(wm ? mosi : shared), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .sdioOut(sdioOut), .sdioOe(sdioOe), .wireModeSelect(wm), .angleValue(angleValue),
        .measureDone(measureDone), .measureStart(measureStart),
        .resultReadyN(resultReadyN), .porCellOff(porCellOff), .gainControl(gainControl));
    spi_host_model spi_host_model_i (.sclk(sclk), .selectN(selectN), .mosi(mosi),
        .hostOe(hostOe), .line(wm ? miso : shared));
    // measurement engine stub: done pulse 20 clocks after start
    always @(posedge clock) begin
        measureDone <= (busy == 1);
        if (!wm && sdoOe) sawOe <= 1'b1;
        if (measureStart) begin
            busy <= 20;
            nStarts <= nStarts + 1;
            angleValue <= angleNext;
        end else if (busy > 0) begin
            busy <= busy - 1;
        end
    end
    function automatic logic [15:0] cmd(logic rd, logic [13:0] a);
        return {rd, a, ^{rd, a}};
    endfunction
    function automatic logic [15:0] ans(logic [13:0] d, logic ef);
        return {d, ef, ^{d, ef}};
    endfunction
    function automatic logic [31:0] step(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic closeOut();
        $display("counts: %0d compares, %0d mismatches", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        nTests++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic xfer(input logic [15:0] tx, input int n = 16, input logic drv = 1'b1);
        @(posedge clock);
        #1;
        spi_host_model_i.frame(tx, n, drv, rx);
        chk(16'(sdoOe | sdioOe), 16'h0000, "line released");
    endtask
    task automatic waitReady();
        int k;
        for (k = 0; k < 300 && resultReadyN !== 1'b0; k++) @(posedge clock);
        if (k == 300) begin
            nErrors++;
            $display("BAD %0t ready never came", $time);
            closeOut();
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        sys_rst = 1'b1;
        wm = 1'b1;
        angleNext = 14'h0000;
        old = GAIN_RST;
        repeat (5) @(posedge clock);
        #1 sys_rst = 1'b0;
        chk(16'(gainControl), 16'h0020, "gain reset");
        chk(16'(resultReadyN | porCellOff | sdoOe), 16'h0000, "reset outputs");
        repeat (3) @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            lfsr = step(lfsr);
            g = (i == 0) ? 6'h3F : (i == 3) ? 6'h00 : lfsr[5:0];
            xfer(cmd(1'b0, ADDR_GAIN));
            xfer(ans({8'h00, g}, lfsr[9]));
            chk(rx, ans({8'h00, old}, 1'b0), "old contents");
            xfer(cmd(1'b1, ADDR_GAIN));
            chk(rx, ans({8'h00, g}, 1'b0), "new contents");
            chk(16'(gainControl), 16'(g), "gain port");
            old = g;
        end
        $display("test gain done");
        for (int i = 0; i < 2; i++) begin
            xfer(cmd(1'b0, ADDR_POR_DISABLE));
            xfer(ans({6'h00, POR_KEY + 8'(i)}, 1'b0));
            chk(16'(porCellOff), 16'(i == 0), "reset cell off");
        end
        $display("test key done");
        lfsr = step(lfsr);
        xfer(cmd(1'b0, ADDR_SETUP));
        xfer(ans({5'h00, lfsr[8:0]}, 1'b0));
        xfer(cmd(1'b1, ADDR_SETUP));
        chk(16'({rx[15:14], rx[10:2]}), 16'({SETUP_RESOLUTION, lfsr[8:0]}), "setup bits");
        $display("test setup done");
        lfsr = step(lfsr);
        a1 = lfsr[13:0];
        angleNext = a1;
        xfer(cmd(1'b1, ADDR_ANGLE));
        chk(16'(resultReadyN), 16'h0001, "measuring");
        waitReady();
        angleNext = ~a1;
        xfer(cmd(1'b1, ADDR_ANGLE));
        chk(rx, ans(14'h0000, 1'b0), "first capture");
        waitReady();
        xfer(cmd(1'b0, ADDR_SOFT_RESET));
        chk(rx, ans(a1, 1'b0), "measured angle");
        angleNext = lfsr[27:14];
        xfer(ans(14'h0001, 1'b0));
        chk(16'(gainControl), 16'h0020, "soft reset gain");
        chk(16'(resultReadyN), 16'h0001, "hidden conversion");
        waitReady();
        xfer(cmd(1'b1, ADDR_ANGLE));
        waitReady();
        xfer(cmd(1'b0, ADDR_NOP));
        chk(rx, ans(~a1, 1'b0), "hidden result unseen");
        chk(16'(nStarts), 16'h0004, "measure starts");
        $display("test angle done");
        xfer(cmd(1'b0, ADDR_GAIN));
        xfer(ans(14'h0011, 1'b0));
        xfer(cmd(1'b0, ADDR_FULL_RESET));
        chk(16'(gainControl), 16'h0020, "full reset gain");
        waitReady();
        xfer(cmd(1'b1, ADDR_GAIN));
        xfer(cmd(1'b1, ADDR_GAIN));
        chk(rx, ans({8'h00, GAIN_RST}, 1'b0), "no data frame");
        $display("test reset done");
        xfer(cmd(1'b1, ADDR_GAIN) ^ 16'h0001);
        xfer(cmd(1'b1, ADDR_ERR_STATUS));
        chk(16'(rx[1]), 16'h0001, "flag after parity");
        xfer(cmd(1'b1, ADDR_ERR_CLEAR));
        chk(rx, ans(14'h0001, 1'b1), "parity status");
        for (int i = 0; i < 3; i++) begin
            lfsr = step(lfsr);
            if (i == 2) xfer(cmd(1'b1, {2'h1, lfsr[11:0]}));
            else xfer(cmd(1'b1, ADDR_GAIN), 15 + 2 * i);
            xfer(cmd(1'b1, ADDR_ERR_CLEAR));
            chk(16'(rx[1]), 16'h0001, "flag held");
            xfer(cmd(1'b0, ADDR_NOP));
            chk(rx, ans(14'h0000, 1'b0), "flag cleared");
        end
        $display("test errors done");
        wm = 1'b0;
        repeat (4) @(posedge clock);
        xfer(cmd(1'b1, ADDR_GAIN));
        xfer(16'h0000, 16, 1'b0);
        chk(rx, ans({8'h00, GAIN_RST}, 1'b0), "shared line answer");
        chk(16'(sawOe), 16'h0000, "no separate output");
        $display("test three wire done");
        closeOut();
    end
endmodule

// [bench/spi_host_model.sv]
// Purpose: host side of the serial register link
// Assumes: each frame is started just after a clock rise
// Notes: a released data line shows the inverse of its last value
`timescale 1ns/100ps
module spi_host_model (
    // link pins
    output logic sclk,
    output logic selectN,
    output logic mosi,
    output logic hostOe,
    // resolved data line seen by the host
    input wire logic line
);
    initial begin
        sclk = 1'b0;
        selectN = 1'b1;
        mosi = 1'b0;
        hostOe = 1'b0;
    end
    // frame, shift on rise, sample on fall
    task automatic frame(input logic [15:0] tx, input int nClk, input logic drv,
                         output logic [15:0] rx);
        rx = 16'h0000;
        selectN = 1'b0;
        #60;
        for (int i = 0; i < nClk; i++) begin
            sclk = 1'b1;
            mosi = tx[15 - (i % 16)];
            hostOe = drv;
            #40;
            sclk = 1'b0;
            rx = {rx[14:0], line};
            #40;
        end
        selectN = 1'b1;
        hostOe = 1'b0;
        mosi = ~mosi;
        #80;
    endtask
endmodule

// [pkg/angle_spi_pkg.sv]
// Purpose: shared constants of the angle sensor serial register port
// Assumes: 16-bit frames, 14-bit register addresses and data
// Notes: addresses are register addresses on the serial link
package angle_spi_pkg;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_COUNT = 5'h10;
    localparam int CMD_DIR_POS = 15;
    localparam int SPI_RESET_POS = 2;
    localparam logic [13:0] ADDR_NOP = 14'h0000;
    localparam logic [13:0] ADDR_ERR_STATUS = 14'h335A;
    localparam logic [13:0] ADDR_ERR_CLEAR = 14'h3380;
    localparam logic [13:0] ADDR_FULL_RESET = 14'h33A5;
    localparam logic [13:0] ADDR_SOFT_RESET = 14'h3C00;
    localparam logic [13:0] ADDR_SETUP = 14'h3F20;
    localparam logic [13:0] ADDR_POR_DISABLE = 14'h3F22;
    localparam logic [13:0] ADDR_GAIN = 14'h3FF8;
    localparam logic [13:0] ADDR_ANGLE = 14'h3FFF;
    localparam logic [7:0] POR_KEY = 8'h5A;
    localparam logic [7:0] POR_DISABLE_RST = 8'h00;
    localparam logic [5:0] GAIN_RST = 6'h20;
    localparam logic [8:0] SETUP_RST = 9'h000;
    localparam logic [1:0] SETUP_RESOLUTION = 2'h0;
    localparam int ERR_PARITY_POS = 0;
    localparam int ERR_BUSY_POS = 1;
endpackage

// [verilog/angle_spi_port.sv]
// Purpose: serial register port of a magnetic angle sensor, slave only
// Assumes: link pins are asynchronous and are oversampled by clock (100 MHz)
// Notes: link clock period must be at least 80 ns for the sampling to keep up
`timescale 1ns/100ps

module angle_spi_port #(
    parameter logic [2:0] CHIP_ID = 3'h5 // arbitrary value
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // serial link pins
    input wire logic sclk,
    input wire logic selectN,
    input wire logic sdiIn,
    output logic sdoOut,
    output logic sdoOe,
    output logic sdioOut,
    output logic sdioOe,
    // strap
    input wire logic wireModeSelect,
    // measurement engine
    input wire logic [13:0] angleValue,
    input wire logic measureDone,
    output logic measureStart,
    output logic resultReadyN,
    // settings
    output logic porCellOff,
    output logic [5:0] gainControl
);
    import angle_spi_pkg::*;

    if (CHIP_ID === 3'bxxx) begin : g_bad_id
        $error("chip id must be a known value");
    end

    typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_RESP} phase_t;

    typedef struct packed {
        logic sclkS1, sclkS2, sclkD;
        logic selS1, selS2, selD;
        logic sdiS1, sdiS2;
        logic wmS1, wmS2;
        logic [15:0] rxShift;
        logic [4:0] bitCnt;
        logic [15:0] txShift;
        logic sdoBit, oe4, oe3;
        logic [13:0] txData;
        phase_t phase;
        logic [13:0] pendAddr;
        logic commErr, parityErr, busy, hideAngle;
        logic [13:0] angleReg;
        logic [5:0] gain;
        logic [7:0] porDisable;
        logic porOff;
        logic [8:0] setupBits;
        logic measStart, readyN;
    } state_t;

    state_t s, next_s;
    logic selRise, selFall, countOk;

    function automatic logic [13:0] regData(input state_t st, input logic [13:0] a);
        logic [13:0] d;
        d = 14'h0000;
        case (a)
            ADDR_ERR_STATUS: begin
                d[ERR_PARITY_POS] = st.parityErr;
                d[ERR_BUSY_POS] = st.busy;
            end
            ADDR_SETUP: d = {SETUP_RESOLUTION, CHIP_ID, st.setupBits};
            ADDR_POR_DISABLE: d = {6'h00, st.porDisable};
            ADDR_GAIN: d = {8'h00, st.gain};
            ADDR_ANGLE: d = st.angleReg;
            default: d = 14'h0000;
        endcase
        return d;
    endfunction

    function automatic logic knownRead(input logic [13:0] a);
        return a == ADDR_ERR_STATUS || a == ADDR_ERR_CLEAR || a == ADDR_SETUP ||
            a == ADDR_POR_DISABLE || a == ADDR_GAIN || a == ADDR_ANGLE;
    endfunction

    // shared by soft and full reset: defaults plus hidden conversion
    function automatic state_t coreReset(input state_t st, input logic serial);
        state_t r;
        r = st;
        r.gain = GAIN_RST;
        r.porDisable = POR_DISABLE_RST;
        r.porOff = 1'b0;
        r.measStart = 1'b1;
        r.busy = 1'b1;
        r.readyN = 1'b1;
        r.hideAngle = 1'b1;
        if (serial) begin
            r.commErr = 1'b0;
            r.parityErr = 1'b0;
            r.txData = 14'h0000;
        end
        return r;
    endfunction

    assign selRise = !s.selD && s.selS2;
    assign selFall = s.selD && !s.selS2;
    assign countOk = s.bitCnt == FRAME_COUNT;

    always_comb begin
        logic [13:0] addr;
        logic [13:0] wdata;
        next_s = s;
        addr = s.rxShift[14:1];
        wdata = s.rxShift[15:2];
        next_s.sclkS1 = sclk;
        next_s.sclkS2 = s.sclkS1;
        next_s.sclkD = s.sclkS2;
        next_s.selS1 = selectN;
        next_s.selS2 = s.selS1;
        next_s.selD = s.selS2;
        next_s.sdiS1 = sdiIn;
        next_s.sdiS2 = s.sdiS1;
        next_s.wmS1 = wireModeSelect;
        next_s.wmS2 = s.wmS1;
        next_s.measStart = 1'b0;
        // shared line driven only in a response frame
        next_s.oe3 = !s.wmS2 && !s.selS2 && s.phase == PH_RESP;
        next_s.oe4 = s.wmS2 && !s.selS2;
        if (s.busy && measureDone) begin
            next_s.busy = 1'b0;
            next_s.readyN = 1'b0;
            next_s.hideAngle = 1'b0;
            if (!s.hideAngle) begin
                next_s.angleReg = angleValue;
            end
        end
        if (selFall) begin
            // frame with error flag and even parity
            next_s.txShift = {s.txData, s.commErr, ^{s.txData, s.commErr}};
            next_s.bitCnt = 5'h00;
        end else if (!s.selS2) begin
            // sample on falling edge, shift out on rising, MSB first
            if (s.sclkD && !s.sclkS2) begin
                next_s.rxShift = {s.rxShift[14:0], s.sdiS2};
                if (s.bitCnt != 5'h1F) begin
                    next_s.bitCnt = s.bitCnt + 5'h01;
                end
            end
            if (!s.sclkD && s.sclkS2) begin
                next_s.sdoBit = s.txShift[15];
                next_s.txShift = {s.txShift[14:0], 1'b0};
            end
        end
        if (selRise) begin
            case (s.phase)
                PH_RESP: begin
                    next_s.phase = PH_CMD;
                end
                PH_DATA: begin
                    next_s.phase = PH_CMD;
                    if (!countOk) begin
                        next_s.commErr = 1'b1;
                    end else if (^s.rxShift) begin
                        next_s.commErr = 1'b1;
                        next_s.parityErr = 1'b1;
                    end else begin
                        // value from bits 15:2, bit 1 ignored
                        case (s.pendAddr)
                            // reset cell switched off by key
                            ADDR_POR_DISABLE: begin
                                next_s.porDisable = wdata[7:0];
                                next_s.porOff = wdata[7:0] == POR_KEY;
                            end
                            ADDR_GAIN: next_s.gain = wdata[5:0];
                            ADDR_SETUP: next_s.setupBits = wdata[8:0];
                            // bit 2 also resets the serial registers
                            ADDR_SOFT_RESET: begin
                                next_s = coreReset(next_s, s.rxShift[SPI_RESET_POS]);
                            end
                            default: next_s.commErr = 1'b1;
                        endcase
                        // new contents follow in the next frame
                        if (s.pendAddr != ADDR_SOFT_RESET) begin
                            next_s.txData = regData(next_s, s.pendAddr);
                        end
                    end
                end
                PH_CMD: begin
                    // bad count is flagged, not executed
                    if (!countOk) begin
                        next_s.commErr = 1'b1;
                    end else if (^s.rxShift) begin
                        next_s.commErr = 1'b1;
                        next_s.parityErr = 1'b1;
                    end else if (s.rxShift[CMD_DIR_POS]) begin
                        if (!knownRead(addr)) begin
                            next_s.commErr = 1'b1;
                        end else begin
                            next_s.txData = regData(s, addr);
                            next_s.phase = s.wmS2 ? PH_CMD : PH_RESP;
                        end
                        if (addr == ADDR_ERR_CLEAR) begin
                            next_s.commErr = 1'b0;
                            next_s.txData = 14'h0000;
                        end
                        if (addr == ADDR_ANGLE) begin
                            next_s.measStart = 1'b1;
                            next_s.busy = 1'b1;
                            next_s.readyN = 1'b1;
                        end
                    end else if (addr == ADDR_FULL_RESET) begin
                        next_s = coreReset(next_s, 1'b1);
                    end else if (addr == ADDR_NOP) begin
                        next_s.txData = 14'h0000;
                    end else if (addr == ADDR_SOFT_RESET || addr == ADDR_SETUP ||
                        addr == ADDR_POR_DISABLE || addr == ADDR_GAIN) begin
                        // write command waits for its data frame
                        next_s.phase = PH_DATA;
                        next_s.pendAddr = addr;
                        next_s.txData = regData(s, addr);
                    end else begin
                        next_s.commErr = 1'b1;
                    end
                end
                default: next_s.phase = PH_CMD;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.selS1 <= 1'b1;
            s.selS2 <= 1'b1;
            s.selD <= 1'b1;
            s.gain <= GAIN_RST;
            s.setupBits <= SETUP_RST;
        end else begin
            s <= next_s;
        end
    end

    assign sdoOut = s.sdoBit;
    assign sdioOut = s.sdoBit;
    // strap picks which pin carries the answer
    assign sdoOe = s.oe4;
    assign sdioOe = s.oe3;
    assign measureStart = s.measStart;
    // low once ready, high during a measurement
    assign resultReadyN = s.readyN;
    assign porCellOff = s.porOff;
    assign gainControl = s.gain;

    a_idle_release: assert property (@(posedge clock) disable iff (sys_rst)
        s.selS2 |=> !sdoOe && !sdioOe) else $error("data pin driven while deselected");
    a_wire_choice: assert property (@(posedge clock) disable iff (sys_rst)
        sdioOe |-> !sdoOe && !$past(s.wmS2)) else $error("wrong pin driven for mode");
    a_start_busy: assert property (@(posedge clock) disable iff (sys_rst)
        measureStart |-> resultReadyN && s.busy) else $error("measure without busy");
    a_ready_done: assert property (@(posedge clock) disable iff (sys_rst)
        s.busy && measureDone && !selRise |=> !resultReadyN) else $error("ready not low");
    a_bad_count: assert property (@(posedge clock) disable iff (sys_rst)
        selRise && !countOk && s.phase != PH_RESP |=> s.commErr)
        else $error("bad clock count not flagged");
    a_parity_flag: assert property (@(posedge clock) disable iff (sys_rst)
        selRise && countOk && s.phase == PH_CMD && ^s.rxShift |=> s.parityErr && s.commErr)
        else $error("parity error not flagged");
    a_clear_flag: assert property (@(posedge clock) disable iff (sys_rst)
        selRise && countOk && s.phase == PH_CMD && !(^s.rxShift) && s.rxShift[15]
        && s.rxShift[14:1] == ADDR_ERR_CLEAR |=> !s.commErr && s.txData == 14'h0000)
        else $error("clear did not clear");
    a_frame_parity: assert property (@(posedge clock) disable iff (sys_rst)
        selFall |=> !(^s.txShift) && s.txShift[1] == $past(s.commErr))
        else $error("answer frame malformed");
    a_gain_field: assert property (@(posedge clock) disable iff (sys_rst)
        selRise && s.phase == PH_DATA && countOk && !(^s.rxShift) && s.pendAddr == ADDR_GAIN
        |=> gainControl == $past(s.rxShift[7:2])) else $error("gain not written");
endmodule
